//--- include/dbrr_pkg.sv
// shared constants and types for the row and refresh command link
//------------------------------------------------------------
//------------------------------------------------------------
package dbrr_pkg;
  localparam int CLK_NS   = 8;
  localparam int CK_DIV   = 4;                 // clk cycles per link clock half period
  localparam int CK_NS    = CLK_NS * 2 * CK_DIV;
  localparam int NGRP     = 4;
  localparam int NBANK    = 16;
  localparam int ROW_W    = 18;
  localparam int AP_BIT   = 10;
  localparam int OTF_BIT  = 0;                 // group bit choosing the refresh type
  // times in ns
  localparam int RP_NS      = 15;
  localparam int RC_NS      = 48;
  localparam int RRDS_NS    = 5;
  localparam int RRDL_NS    = 7;
  localparam int FAW_NS     = 30;
  localparam int RFC_NS     = 350;
  localparam int RESTORE_NS = 33;
  localparam int WRDONE_NS  = 45;
  localparam int REFI_NS    = 7800;
  localparam int REFI_HOT_NS = 3900;

  // least times round up, longest times round down, never below one cycle
  function automatic int ck_up(input int ns);
    return ((ns + CK_NS - 1) / CK_NS < 1) ? 1 : (ns + CK_NS - 1) / CK_NS;
  endfunction : ck_up
  function automatic int ck_dn(input int ns);
    return (ns / CK_NS < 1) ? 1 : ns / CK_NS;
  endfunction : ck_dn

  localparam logic [7:0] RP_CK       = 8'(ck_up(RP_NS));
  localparam logic [7:0] RC_CK       = 8'(ck_up(RC_NS));
  localparam logic [7:0] RRDS_CK     = 8'(ck_up(RRDS_NS));
  localparam logic [7:0] RRDL_CK     = 8'(ck_up(RRDL_NS));
  localparam logic [7:0] FAW_CK      = 8'(ck_up(FAW_NS));
  localparam logic [7:0] RFC_CK      = 8'(ck_up(RFC_NS));
  localparam logic [7:0] RESTORE_CK  = 8'(ck_up(RESTORE_NS));
  localparam logic [7:0] WRDONE_CK   = 8'(ck_up(WRDONE_NS));
  localparam logic [7:0] REFI_CK     = 8'(ck_dn(REFI_NS));
  localparam logic [7:0] REFI_HOT_CK = 8'(ck_dn(REFI_HOT_NS));
  localparam logic signed [6:0] POST_1X = 7'sh08;  // postpone limit in 1x mode
  localparam logic signed [6:0] PULL_1X = 7'sh08;  // pull-in limit in 1x mode

  // pin levels {cs_n, act_n, ras_n, cas_n, we_n}
  localparam logic [4:0] ENC_DES = 5'h1f;
  localparam logic [4:0] ENC_ACT = 5'h07;
  localparam logic [4:0] ENC_PRE = 5'h0a;
  localparam logic [4:0] ENC_REF = 5'h09;
  localparam logic [4:0] ENC_RD  = 5'h0d;
  localparam logic [4:0] ENC_WR  = 5'h0c;

  typedef enum logic [2:0] {
    CMD_ACT  = 3'h0,
    CMD_PRE  = 3'h1,
    CMD_PREA = 3'h2,
    CMD_RD   = 3'h3,
    CMD_WR   = 3'h4,
    CMD_REF  = 3'h5
  } dbrr_cmd_t;

  typedef enum logic [1:0] {
    RMODE_1X = 2'h0,
    RMODE_2X = 2'h1,
    RMODE_4X = 2'h2
  } dbrr_rmode_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'h1,
    ST_FLUSH = 2'h2
  } dbrr_cst_t;
endpackage : dbrr_pkg

//--- include/dbrr_if.sv
// command link between controller and memory device
interface dbrr_if
  import dbrr_pkg::*;
;
  logic             ck;
  logic             cs_n;
  logic             act_n;
  logic             ras_n;
  logic             cas_n;
  logic             we_n;
  logic [1:0]       bg;
  logic [1:0]       ba;
  logic [ROW_W-1:0] addr;

  modport ctrl (output ck, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr);
  modport dram (input ck, cs_n, act_n, ras_n, cas_n, we_n, bg, ba, addr);
endinterface : dbrr_if

//--- hw/dbrr_dram.sv
// memory device end: bank row state, auto precharge and refresh counter
module dbrr_dram
  import dbrr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              tcr_en,
  input  wire logic              tcr_ext,
  input  wire logic              temp_cold,
  input  wire logic              temp_hot,
  output logic [NBANK-1:0]       open_mask,
  output logic                   proto_err,
  output logic [15:0]            int_ref_cnt,
  dbrr_if.dram                   link
);
  typedef struct packed {
    logic [3:0]                    s1;
    logic [3:0]                    s2;
    logic [NBANK-1:0]              open;
    logic [NBANK-1:0][ROW_W-1:0]   row;
    logic [NBANK-1:0]              ap_pend;
    logic [NBANK-1:0][7:0]         ap_cnt;
    logic [NBANK-1:0][7:0]         rp;
    logic [7:0]                    rfc;
    logic [ROW_W-1:0]              ref_row;
    logic [1:0]                    gear;
    logic                          tgl;
    logic                          err;
  } dbrr_dk_t;

  typedef struct packed {
    logic [NBANK-1:0] om1;
    logic [NBANK-1:0] om2;
    logic [NBANK-1:0] om3;
    logic [NBANK-1:0] omo;
    logic             e1;
    logic             e2;
    logic             t1;
    logic             t2;
    logic             t3;
    logic [15:0]      cnt;
  } dbrr_du_t;

  dbrr_dk_t k_r, k_nxt;
  dbrr_du_t u_r, u_nxt;
  logic [4:0] pins;
  logic [3:0] b;
  logic       busy_any;
  logic [1:0] mask;
  logic       ten, text, tcold, thot;

  assign pins = {link.cs_n, link.act_n, link.ras_n, link.cas_n, link.we_n};
  assign b    = {link.bg, link.ba};

  // link clock side: decode sampled pins and update bank state
  always_comb begin
    k_nxt = k_r;
    k_nxt.s1 = {tcr_en, tcr_ext, temp_cold, temp_hot};
    k_nxt.s2 = k_r.s1;
    {ten, text, tcold, thot} = k_r.s2;
    busy_any = 1'b0;
    mask = 2'h0;
    // timers and delayed auto precharge
    for (int i = 0; i < NBANK; i++) begin
      if (k_r.rp[i] != 8'h0) k_nxt.rp[i] = k_r.rp[i] - 8'h1;
      if (k_r.open[i] || k_r.rp[i] != 8'h0) busy_any = 1'b1;
      if (k_r.ap_pend[i]) begin
        if (k_r.ap_cnt[i] == 8'h0) begin
          k_nxt.ap_pend[i] = 1'b0;
          k_nxt.open[i]    = 1'b0;
          k_nxt.rp[i]      = RP_CK;
        end else begin
          k_nxt.ap_cnt[i] = k_r.ap_cnt[i] - 8'h1;
        end
      end
    end
    if (k_r.rfc != 8'h0) begin
      k_nxt.rfc = k_r.rfc - 8'h1;
      if (!link.cs_n) k_nxt.err = 1'b1;
    end else begin
      case (pins)
        ENC_ACT: begin
          if (k_r.open[b] || k_r.rp[b] != 8'h0) k_nxt.err = 1'b1;
          else begin
            k_nxt.open[b] = 1'b1;
            k_nxt.row[b]  = link.addr;
          end
        end
        ENC_PRE: begin
          for (int i = 0; i < NBANK; i++) begin
            if (link.addr[AP_BIT] || 4'(i) == b) begin
              k_nxt.open[i]    = 1'b0;
              k_nxt.ap_pend[i] = 1'b0;
              k_nxt.rp[i]      = RP_CK;
            end
          end
        end
        ENC_RD, ENC_WR: begin
          if (!k_r.open[b] || k_r.ap_pend[b]) k_nxt.err = 1'b1;
          else if (link.addr[AP_BIT]) begin
            k_nxt.ap_pend[b] = 1'b1;
            k_nxt.ap_cnt[b]  = (pins == ENC_WR) ? WRDONE_CK : RESTORE_CK;
          end
        end
        ENC_REF: begin
          if (busy_any) k_nxt.err = 1'b1;
          k_nxt.rfc  = RFC_CK;
          k_nxt.gear = k_r.gear + 2'h1;
          // gear ratio: 1, 2 or 4 external refreshes per internal one
          if (ten && tcold && text) mask = 2'h3;
          else if (ten && (tcold || (text && !thot))) mask = 2'h1;
          if ((k_r.gear & mask) == 2'h0) begin
            k_nxt.ref_row = k_r.ref_row + 18'h1;
            k_nxt.tgl     = ~k_r.tgl;
          end
          k_nxt.open    = '0;
          k_nxt.ap_pend = '0;
        end
        default: ;
      endcase
    end
  end

  // link clock registers
  always_ff @(posedge link.ck or posedge sys_rst) begin
    if (sys_rst) k_r <= '0;
    else k_r <= k_nxt;
  end

  // system clock side: synchronise levels and the refresh toggle
  always_comb begin
    u_nxt = u_r;
    u_nxt.om1 = k_r.open;
    u_nxt.om2 = u_r.om1;
    u_nxt.om3 = u_r.om2;
    // the mask is a word: take it only once two samples agree, never torn
    if (u_r.om2 == u_r.om3) u_nxt.omo = u_r.om2;
    u_nxt.e1  = k_r.err;
    u_nxt.e2  = u_r.e1;
    u_nxt.t1  = k_r.tgl;
    u_nxt.t2  = u_r.t1;
    u_nxt.t3  = u_r.t2;
    if (u_r.t2 != u_r.t3) u_nxt.cnt = u_r.cnt + 16'h1;   // one per internal refresh
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) u_r <= '0;
    else u_r <= u_nxt;
  end

  assign open_mask   = u_r.omo;
  assign proto_err   = u_r.e2;
  assign int_ref_cnt = u_r.cnt;
endmodule : dbrr_dram

//--- hw/dbrr_ctrl.sv
// controller end: makes the link clock, spaces commands, owns refresh credit
module dbrr_ctrl
  import dbrr_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire dbrr_cmd_t         req_cmd,
  input  wire logic [1:0]        req_bg,
  input  wire logic [1:0]        req_ba,
  input  wire logic [ROW_W-1:0]  req_row,
  input  wire logic              req_ap,
  input  wire dbrr_rmode_t       ref_mode,
  input  wire logic              temp_hot,
  output logic signed [6:0]      ref_owed,
  output logic                   ref_forced,
  dbrr_if.ctrl                   link
);
  typedef struct packed {
    dbrr_cst_t                     st;
    logic [3:0]                    div;
    logic                          ck;
    logic [4:0]                    pins;
    logic [1:0]                    bg;
    logic [1:0]                    ba;
    logic [ROW_W-1:0]              addr;
    logic [NBANK-1:0]              open;
    logic [NBANK-1:0][ROW_W-1:0]   row;
    logic [NBANK-1:0][7:0]         rp;
    logic [NBANK-1:0][7:0]         rc;
    logic [NGRP-1:0][7:0]          rrdl;
    logic [7:0]                    rrds;
    logic [7:0]                    rfc;
    logic [7:0]                    refi;
    logic [3:0][7:0]               faw;
    logic [1:0]                    fidx;
    logic signed [6:0]             owed;
  } dbrr_cs_t;

  dbrr_cs_t r, n;

  logic              fall;
  logic              ok;
  logic              rp_done;
  logic              forced;
  logic              issue;
  dbrr_cmd_t         icmd;
  logic [3:0]        ib;
  logic [ROW_W-1:0]  irow;
  logic              iap;
  logic signed [6:0] max_post;
  logic signed [6:0] max_pull;
  logic [7:0]        refi_len;

  function automatic logic [7:0] dec(input logic [7:0] v);
    return (v == 8'h0) ? v : v - 8'h1;
  endfunction : dec

  // limits and interval for the selected refresh mode
  always_comb begin
    case (ref_mode)
      RMODE_2X: begin
        max_post = POST_1X <<< 1;
        max_pull = PULL_1X <<< 1;
      end
      RMODE_4X: begin
        max_post = POST_1X <<< 2;
        max_pull = PULL_1X <<< 2;
      end
      default: begin
        max_post = POST_1X;
        max_pull = PULL_1X;
      end
    endcase
    refi_len = (temp_hot ? REFI_HOT_CK : REFI_CK) >> ref_mode;
  end

  // legality of the user request against tracked state
  always_comb begin
    rp_done = 1'b1;
    for (int i = 0; i < NBANK; i++) begin
      if (r.rp[i] != 8'h0) rp_done = 1'b0;
    end
    case (req_cmd)
      CMD_ACT: ok = !r.open[{req_bg, req_ba}]
                 && r.rp[{req_bg, req_ba}] == 8'h0
                 && r.rc[{req_bg, req_ba}] == 8'h0
                 && r.rrds == 8'h0 && r.rrdl[req_bg] == 8'h0
                 && r.faw[r.fidx] == 8'h0;
      CMD_PRE, CMD_PREA: ok = 1'b1;
      CMD_RD, CMD_WR: ok = r.open[{req_bg, req_ba}];
      CMD_REF: ok = (r.open == '0) && rp_done && (r.owed > -max_pull);
      default: ok = 1'b0;
    endcase
    forced    = r.owed >= max_post;
    req_ready = fall && ok && r.rfc == 8'h0 && r.st == ST_RUN && !forced;
  end

  // next state: clock divider, timers, command issue and refresh credit
  always_comb begin
    n = r;
    fall = r.div == 4'(CK_DIV - 1);
    n.div = (r.div == 4'(2 * CK_DIV - 1)) ? 4'h0 : r.div + 4'h1;
    n.ck = n.div < 4'(CK_DIV);
    issue = 1'b0;
    icmd = req_cmd;
    ib = {req_bg, req_ba};
    irow = req_row;
    iap = req_ap;
    if (fall) begin
      // every timer counts link clock periods
      n.pins = ENC_DES;
      n.rrds = dec(r.rrds);
      n.rfc  = dec(r.rfc);
      for (int i = 0; i < NBANK; i++) begin
        n.rp[i] = dec(r.rp[i]);
        n.rc[i] = dec(r.rc[i]);
      end
      for (int g = 0; g < NGRP; g++) n.rrdl[g] = dec(r.rrdl[g]);
      for (int f = 0; f < 4; f++) n.faw[f] = dec(r.faw[f]);
      // refresh interval tick owes one more refresh
      if (r.refi == 8'h0) begin
        n.refi = refi_len - 8'h1;
        if (r.owed != 7'sh3f) n.owed = r.owed + 7'sh01;
      end else begin
        n.refi = r.refi - 8'h1;
      end
      // state machine: forced refresh closes banks, then refreshes
      case (r.st)
        ST_RUN: begin
          if (forced) n.st = ST_FLUSH;
          else if (req_valid && req_ready) issue = 1'b1;
        end
        ST_FLUSH: begin
          if (r.rfc != 8'h0) begin
            issue = 1'b0;
          end else if (r.open != '0) begin
            issue = 1'b1;
            icmd = CMD_PREA;
          end else if (rp_done) begin
            issue = 1'b1;
            icmd = CMD_REF;
            n.st = ST_RUN;
          end
        end
        default: n.st = ST_RUN;
      endcase
    end
    if (issue) begin
      n.bg   = ib[3:2];
      n.ba   = ib[1:0];
      n.addr = '0;
      case (icmd)
        CMD_ACT: begin
          n.pins         = ENC_ACT;
          n.addr         = irow;
          n.open[ib]     = 1'b1;
          n.row[ib]      = irow;
          n.rc[ib]       = RC_CK;
          n.rrds         = RRDS_CK;
          n.rrdl[ib[3:2]] = RRDL_CK;
          n.faw[r.fidx]  = FAW_CK;
          n.fidx         = r.fidx + 2'h1;
        end
        CMD_PRE: begin
          n.pins     = ENC_PRE;
          n.open[ib] = 1'b0;
          n.rp[ib]   = RP_CK;
        end
        CMD_PREA: begin
          n.pins         = ENC_PRE;
          n.addr[AP_BIT] = 1'b1;
          n.open         = '0;
          for (int i = 0; i < NBANK; i++) n.rp[i] = RP_CK;
        end
        CMD_RD, CMD_WR: begin
          n.pins         = (icmd == CMD_WR) ? ENC_WR : ENC_RD;
          n.addr[AP_BIT] = iap;
          if (iap) begin
            // bank stays busy for the hidden precharge, its delay and the
            // extra link period the device needs to start it
            n.open[ib] = 1'b0;
            n.rp[ib]   = RP_CK + 8'h1 + ((icmd == CMD_WR) ? WRDONE_CK : RESTORE_CK);
          end
        end
        CMD_REF: begin
          n.pins = ENC_REF;
          n.rfc  = RFC_CK;
          n.bg[OTF_BIT] = ref_mode != RMODE_1X;
          // builds on the interval tick so a tick in the same period is kept
          if (r.owed > -max_pull) n.owed = n.owed - 7'sh01;
        end
        default: n.pins = ENC_DES;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r      <= '0;
      r.div  <= 4'(2 * CK_DIV - 1);                     // first high phase is full
      r.st   <= ST_RUN;
      r.pins <= ENC_DES;
      r.refi <= REFI_CK;
    end else begin
      r <= n;
    end
  end

  // link pins come straight from flops
  assign link.ck    = r.ck;
  assign link.cs_n  = r.pins[4];
  assign link.act_n = r.pins[3];
  assign link.ras_n = r.pins[2];
  assign link.cas_n = r.pins[1];
  assign link.we_n  = r.pins[0];
  assign link.bg    = r.bg;
  assign link.ba    = r.ba;
  assign link.addr  = r.addr;
  assign ref_owed   = r.owed;
  assign ref_forced = r.st == ST_FLUSH;
endmodule : dbrr_ctrl

//--- tb/dbrr_link_properties.sv
// concurrent checks on the command link between controller and device
module dbrr_link_properties
  import dbrr_pkg::*;
(
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             ck,
  input wire logic             cs_n,
  input wire logic             act_n,
  input wire logic             ras_n,
  input wire logic             cas_n,
  input wire logic             we_n,
  input wire logic [1:0]       bg,
  input wire logic [1:0]       ba,
  input wire logic [ROW_W-1:0] addr
);
  timeunit 1ns;
  timeprecision 1ps;
  //--------------------------------------------------------------
  // shadow state
  //--------------------------------------------------------------
  typedef struct packed {
    logic             ck_q;
    logic [NBANK-1:0] open_sh;
    logic [7:0]       since_ref;
    logic [7:0]       since_act;
  } dbrr_chk_t;

  dbrr_chk_t  st_r;
  dbrr_chk_t  st_nxt;
  logic [4:0] cmd;
  logic [3:0] bank;
  logic       rise;

  // command strobes, bank index and link clock rise
  assign cmd  = {cs_n, act_n, ras_n, cas_n, we_n};
  assign bank = {bg, ba};
  assign rise = ck & ~st_r.ck_q;

  // open rows and ages in link clock periods, as the device sees them
  always_comb begin
    st_nxt      = st_r;
    st_nxt.ck_q = ck;
    if (rise) begin
      if (st_r.since_ref != 8'hff) st_nxt.since_ref = st_r.since_ref + 8'h01;
      if (st_r.since_act != 8'hff) st_nxt.since_act = st_r.since_act + 8'h01;
      if (cmd == ENC_ACT) begin
        st_nxt.open_sh[bank] = 1'h1;
        st_nxt.since_act     = 8'h01;
      end
      if (cmd == ENC_PRE) st_nxt.open_sh[bank] = 1'h0;
      if (cmd == ENC_PRE && addr[AP_BIT]) st_nxt.open_sh = '0;
      if ((cmd == ENC_RD || cmd == ENC_WR) && addr[AP_BIT]) st_nxt.open_sh[bank] = 1'h0;
      if (cmd == ENC_REF) st_nxt.since_ref = 8'h01;
    end
  end

  // ages start saturated so the first commands are never flagged
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{ck_q: 1'h0, open_sh: '0, since_ref: 8'hff, since_act: 8'hff};
    end else begin
      st_r <= st_nxt;
    end
  end

  //--------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ck_shape_a: assert property ($rose(ck) |=> ck [*3] ##1 !ck [*4] ##1 ck)
    else $error("link clock is not four high four low");
  pin_hold_a: assert property ($changed({cmd, bank, addr}) |=> $stable({cmd, bank, addr}) [*7])
    else $error("command pins not held a full link period");
  rise_stable_a: assert property ($rose(ck) |-> $stable({cmd, bank, addr}))
    else $error("command pins move at the link clock rise");
  act_closed_a: assert property (rise && cmd == ENC_ACT |-> !st_r.open_sh[bank])
    else $error("activate to a bank with an open row");
  rdwr_open_a: assert property (rise && (cmd == ENC_RD || cmd == ENC_WR) |-> st_r.open_sh[bank])
    else $error("read or write to an idle bank");
  ref_idle_a: assert property (rise && cmd == ENC_REF |-> st_r.open_sh == '0)
    else $error("refresh with a bank still open");
  ref_quiet_a: assert property (rise && cmd != ENC_DES |-> st_r.since_ref >= RFC_CK)
    else $error("command inside the refresh cycle time");
  act_gap_a: assert property (rise && cmd == ENC_ACT |-> st_r.since_act >= RRDS_CK)
    else $error("activates closer than the short spacing");
endmodule : dbrr_link_properties

//--- tb/testbench.sv
// self-checking bench: controller and device joined over the command link
module testbench
  import dbrr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  //--------------------------------------------------------------
  // harness
  //--------------------------------------------------------------
  logic              clk = 1'h0;
  logic              sys_rst = 1'h1;
  logic              req_valid = 1'h0;
  logic              req_ready;
  dbrr_cmd_t         req_cmd = CMD_ACT;
  logic [1:0]        req_bg = 2'h0;
  logic [1:0]        req_ba = 2'h0;
  logic [ROW_W-1:0]  req_row = '0;
  logic              req_ap = 1'h0;
  dbrr_rmode_t       ref_mode = RMODE_1X;
  logic              temp_hot = 1'h0;
  logic              tcr_en = 1'h0;
  logic              tcr_ext = 1'h0;
  logic              temp_cold = 1'h0;
  logic signed [6:0] ref_owed;
  logic              ref_forced;
  logic [NBANK-1:0]  open_mask;
  logic              proto_err;
  logic [15:0]       int_ref_cnt;
  logic [31:0]       seed = 32'h0001265e;
  int                n_errors = 0;
  int                check_count = 0;
  logic [15:0]       exp_q[$];
  logic [15:0]       em = 16'h0000;
  logic [NBANK-1:0]  mask_q = '0;
  logic [15:0]       cnt0;
  logic              tk;
  logic [3:0]        bk_a;
  logic [3:0]        bk_b;

  dbrr_if link_i ();
  dbrr_ctrl dbrr_ctrl_inst (.clk, .sys_rst, .req_valid, .req_ready, .req_cmd, .req_bg, .req_ba,
    .req_row, .req_ap, .ref_mode, .temp_hot, .ref_owed, .ref_forced, .link(link_i.ctrl));
  dbrr_dram dbrr_dram_inst (.clk, .sys_rst, .tcr_en, .tcr_ext, .temp_cold, .temp_hot,
    .open_mask, .proto_err, .int_ref_cnt, .link(link_i.dram));
  dbrr_link_properties dbrr_link_properties_inst (.clk, .sys_rst, .ck(link_i.ck),
    .cs_n(link_i.cs_n), .act_n(link_i.act_n), .ras_n(link_i.ras_n), .cas_n(link_i.cas_n),
    .we_n(link_i.we_n), .bg(link_i.bg), .ba(link_i.ba), .addr(link_i.addr));

  // 125 MHz system clock
  always #4 clk = ~clk;

  //--------------------------------------------------------------
  // tasks
  //--------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic cmp_num(input logic [15:0] e, input logic [15:0] a);
    check_count++;
    if (a !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : cmp_num

  task automatic cmp_mask(input logic [NBANK-1:0] e, input logic [NBANK-1:0] a);
    cmp_num(16'(e), 16'(a));
  endtask : cmp_mask

  // offer a request and hold it until taken or the limit runs out
  task automatic issue(input dbrr_cmd_t c, input logic [3:0] bk, input logic ap, input int lim);
    @(posedge clk);
    req_cmd <= c;
    req_bg <= bk[3:2];
    req_ba <= bk[1:0];
    req_row <= 18'(rnd());
    req_ap <= ap;
    req_valid <= 1'h1;
    tk = 1'h0;
    for (int i = 0; i < lim && !tk; i++) begin
      @(negedge clk);
      tk = req_ready;
      @(posedge clk);
    end
    req_valid <= 1'h0;
  endtask : issue

  task automatic go(input dbrr_cmd_t c, input logic [3:0] bk, input logic ap);
    issue(c, bk, ap, 300);
    if (tk !== 1'h1) begin
      cmp_num(16'h0001, 16'(tk));
      close_out();
    end
  endtask : go

  task automatic deny(input dbrr_cmd_t c, input logic [3:0] bk);
    issue(c, bk, 1'h0, 24);
    cmp_num(16'h0000, 16'(tk));
  endtask : deny

  // note the mask the command should leave, send it, wait for the monitor
  task automatic step(input dbrr_cmd_t c, input logic [3:0] bk, input logic ap,
                      input logic [15:0] m);
    if (m !== em) exp_q.push_back(m);
    em = m;
    go(c, bk, ap);
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge clk);
    cmp_num(16'h0000, 16'(exp_q.size()));
  endtask : step

  task automatic reff();
    go(CMD_REF, 4'(rnd()), 1'h0);
    @(negedge clk);
    if (ref_mode != RMODE_1X) cmp_num(16'h0001, 16'(link_i.bg[OTF_BIT]));
  endtask : reff

  task automatic wait_cnt(input logic [15:0] e);
    for (int i = 0; i < 200 && int_ref_cnt !== e; i++) @(negedge clk);
    cmp_num(e, int_ref_cnt);
  endtask : wait_cnt

  // each change of the open-row mask is matched to the oldest note
  always @(negedge clk) begin
    if (!sys_rst && open_mask !== mask_q) begin
      mask_q = open_mask;
      if (exp_q.size() == 0) begin
        cmp_mask(~open_mask, open_mask);
      end else begin
        cmp_mask(exp_q.pop_front(), open_mask);
      end
    end
  end

  //--------------------------------------------------------------
  // sequence
  //--------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    @(negedge clk);
    cmp_num(16'h0000, 16'(ref_owed));
    bk_a = 4'(rnd());
    bk_b = bk_a ^ 4'h4;
    cnt0 = int_ref_cnt;
    repeat (4) reff();
    @(posedge clk);
    tcr_en <= 1'h1;
    temp_cold <= 1'h1;
    wait_cnt(cnt0 + 16'h0004);
    cnt0 = int_ref_cnt;
    repeat (4) reff();
    wait_cnt(cnt0 + 16'h0002);
    deny(CMD_REF, 4'h0);
    cmp_num(16'hfff8, 16'(ref_owed));
    cmp_num(cnt0 + 16'h0002, int_ref_cnt);
    step(CMD_ACT, bk_a, 1'h0, em | (16'h0001 << bk_a));
    deny(CMD_ACT, bk_a);
    deny(CMD_RD, bk_b);
    step(CMD_ACT, bk_b, 1'h0, em | (16'h0001 << bk_b));
    step(CMD_RD, bk_a, 1'h1, em & ~(16'h0001 << bk_a));
    step(CMD_WR, bk_b, 1'h1, em & ~(16'h0001 << bk_b));
    step(CMD_PRE, bk_a, 1'h0, em);
    step(CMD_ACT, bk_a, 1'h0, em | (16'h0001 << bk_a));
    step(CMD_ACT, bk_b, 1'h0, em | (16'h0001 << bk_b));
    step(CMD_PREA, bk_a, 1'h0, 16'h0000);
    step(CMD_ACT, bk_b, 1'h0, em | (16'h0001 << bk_b));
    @(posedge clk);
    tcr_en <= 1'h0;
    temp_hot <= 1'h1;
    cnt0 = int_ref_cnt;
    exp_q.push_back(16'h0000);
    em = 16'h0000;
    for (int i = 0; i < 9000 && ref_forced !== 1'h1; i++) @(negedge clk);
    cmp_num(16'h0001, 16'(ref_forced));
    cmp_num(16'h0008, 16'(ref_owed));
    for (int i = 0; i < 400 && ref_forced !== 1'h0; i++) @(negedge clk);
    cmp_num(16'h0007, 16'(ref_owed));
    wait_cnt(cnt0 + 16'h0001);
    cmp_num(16'h0000, 16'(exp_q.size()));
    @(posedge clk);
    ref_mode <= RMODE_2X;
    reff();
    cmp_num(16'h0000, 16'(proto_err));
    // cold extended range: one internal refresh per four external ones
    repeat (24) @(posedge clk);
    tcr_en <= 1'h1;
    tcr_ext <= 1'h1;
    cnt0 = int_ref_cnt;
    repeat (4) reff();
    repeat (24) @(negedge clk);
    cmp_num(cnt0 + 16'h0001, int_ref_cnt);
    cmp_num(16'h0000, 16'(proto_err));
    close_out();
  end
endmodule : testbench
